// >>> hdl/smr_lfsr.v
// free running lfsr supplying the six bit challenge code
`default_nettype none
module smr_lfsr (
  input  wire       clk_sys_i,
  input  wire       rst_i,
  output wire [5:0] code_o
);
  reg [15:0] lfsr_q;

  // x^16+x^14+x^13+x^11; nonzero seed keeps it from locking up
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      lfsr_q <= 16'hace1;
    end else begin
      lfsr_q <= {lfsr_q[14:0],
                 lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end
  end

  assign code_o = lfsr_q[5:0];
endmodule // smr_lfsr
`default_nettype wire

// >>> hdl/smr_regs.v
// spi slave with misc setup and special mode registers
`include "smr_consts.vh"
`default_nettype none
module smr_regs (
  input  wire       clk_sys_i,
  input  wire       rst_i,
  input  wire       spi_sclk_i,
  input  wire       spi_cs_n_i,
  input  wire       spi_mosi_i,
  output reg        spi_miso_o,
  input  wire [2:0] dev_mode_i,
  input  wire [1:0] strap_variant_i,
  input  wire       wd_half_i,
  output reg  [7:0] misc_cfg_o,
  output reg        lp_need_code_o,
  output reg        parity_err_o,
  output reg        irq_n_o,
  input  wire       irq_event_i,
  input  wire       irq_clear_i,
  output reg        dbg_res_flag_o,
  output reg  [1:0] variant_o,
  output reg        mode_req_o,
  output reg  [1:0] mode_sel_o,
  output reg        failsafe_n_o,
  output reg        wd_extend_ok_o
);
  localparam [19:0] IRQ_LONG  = `SMR_IRQ_LONG_CYC;
  localparam [19:0] IRQ_SHORT = `SMR_IRQ_SHORT_CYC;
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SHIFT = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  wire       sclk_s;
  wire       cs_sel_s;
  wire       cs_n_s;
  wire       mosi_s;
  wire [5:0] rnd_w;
  reg        sclk_q;
  reg  [2:0] st_q;
  reg  [15:0] sh_q;
  reg  [15:0] tx_q;
  reg  [4:0] cnt_q;
  reg  [7:0] spec_q;
  reg  [5:0] chal_q;
  reg        chal_ok_q;
  reg  [19:0] irq_cnt_q;
  reg        irq_hold_q;
  reg        half_q;

  smr_sync u_sclk (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .d_i       (spi_sclk_i),
    .q_o       (sclk_s)
  );
  smr_sync u_cs (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .d_i       (~spi_cs_n_i),
    .q_o       (cs_sel_s)
  );
  // synchronised as select so reset reads deselected, no false frame start
  assign cs_n_s = ~cs_sel_s;
  smr_sync u_mosi (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .d_i       (spi_mosi_i),
    .q_o       (mosi_s)
  );
  smr_lfsr u_rnd (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .code_o    (rnd_w)
  );

  // frame decode helpers: bit15..14 = 01 write, 00 read
  wire       rise_w  = sclk_s & ~sclk_q;
  wire       fall_w  = ~sclk_s & sclk_q;
  wire [15:0] fr_w   = sh_q;
  wire       wr_w    = (fr_w[15:14] == 2'h1);
  wire [4:0] addr_w  = fr_w[13:9];
  wire       par_w   = fr_w[8];
  wire [7:0] dat_w   = fr_w[7:0];
  // odd parity over the frame's other bits, parity bit included
  wire       par_ok  = ^fr_w;
  wire       in_setup = (dev_mode_i == `SMR_MODE_SETUP);
  wire [5:0] inv_w   = ~chal_q;
  wire       code_ok = chal_ok_q && (dat_w[5:0] == inv_w);
  wire       safe_cd = chal_ok_q &&
                       (dat_w[5:0] == {chal_q[5:4], inv_w[3:0]});
  wire       frame_end = (st_q == ST_SHIFT) && cs_n_s;
  wire       full_w  = (cnt_q == 5'd16);
  // parity error only counts when checking is enabled
  wire       par_bad = misc_cfg_o[`SMR_MISC_PARITY] & ~par_ok;
  wire       wr_go   = frame_end && full_w && wr_w && !par_bad;

  // spi frame engine: sample on rising, shift out on falling
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_q       <= ST_IDLE;
      sclk_q     <= 1'b0;
      sh_q       <= 16'h0000;
      tx_q       <= 16'h0000;
      cnt_q      <= 5'd0;
      spi_miso_o <= 1'b0;
    end else begin
      sclk_q <= sclk_s;
      case (st_q)
        ST_IDLE: begin
          if (!cs_n_s) begin
            st_q  <= ST_SHIFT;
            cnt_q <= 5'd0;
            tx_q  <= 16'h0000;
            spi_miso_o <= 1'b0;
          end
        end
        ST_SHIFT: begin
          if (cs_n_s) begin
            st_q <= ST_DONE;
          end else if (rise_w) begin
            sh_q <= {sh_q[14:0], mosi_s};
            if (cnt_q != 5'd16) begin
              cnt_q <= cnt_q + 5'd1;
            end
            // after the command byte, load the reply for the data byte
            if (cnt_q == 5'd7 && sh_q[6:0] == 7'h09) begin
              tx_q <= {2'b00, rnd_w, 8'h00};
            end
          end else if (fall_w) begin
            spi_miso_o <= tx_q[15];
            tx_q <= {tx_q[14:0], 1'b0};
          end
        end
        ST_DONE: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // register bank and challenge capture
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      misc_cfg_o   <= `SMR_MISC_RST;
      spec_q       <= `SMR_SPEC_RST;
      chal_q       <= 6'h00;
      chal_ok_q    <= 1'b0;
      parity_err_o <= 1'b0;
      mode_req_o   <= 1'b0;
      mode_sel_o   <= 2'h0;
      failsafe_n_o <= 1'b1;
    end else begin
      mode_req_o   <= 1'b0;
      parity_err_o <= frame_end && full_w && wr_w && par_bad;
      // read of special mode register captures the fresh challenge
      if (st_q == ST_SHIFT && rise_w && cnt_q == 5'd7 &&
          sh_q[6:0] == 7'h09) begin
        chal_q    <= rnd_w;
        chal_ok_q <= 1'b1;
      end
      if (wr_go && addr_w == `SMR_ADDR_MISC && in_setup) begin
        misc_cfg_o <= dat_w;
      end
      if (wr_go && addr_w == `SMR_ADDR_SPEC) begin
        chal_ok_q <= 1'b0; // one write per challenge
        spec_q    <= dat_w;
        // failsafe activation: setup target, partially inverted code
        if (in_setup && dat_w[7:6] == `SMR_SEL_SETUP && safe_cd &&
            !code_ok) begin
          failsafe_n_o <= 1'b0;
        end else if (code_ok && dat_w[7:6] != 2'h3) begin
          // setup target only from normal mode
          if (dat_w[7:6] != `SMR_SEL_SETUP ||
              dev_mode_i == `SMR_MODE_NORMAL) begin
            mode_req_o <= 1'b1;
            mode_sel_o <= dat_w[7:6];
          end
        end
      end
    end
  end

  // derived config outputs and debug variant override
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      lp_need_code_o <= 1'b0;
      variant_o      <= 2'h0;
      dbg_res_flag_o <= 1'b0;
      wd_extend_ok_o <= 1'b0;
    end else begin
      lp_need_code_o <= misc_cfg_o[`SMR_MISC_LP_RND];
      wd_extend_ok_o <= (dev_mode_i == `SMR_MODE_REPROG);
      if (misc_cfg_o[`SMR_MISC_DBG_EN]) begin
        // codes 100..111 map to variants b3,b2,b1,a (0..3)
        variant_o <= misc_cfg_o[1:0];
        if (strap_variant_i != misc_cfg_o[1:0]) begin
          dbg_res_flag_o <= 1'b1;
        end else if (irq_clear_i) begin
          dbg_res_flag_o <= 1'b0;
        end
      end else begin
        variant_o <= strap_variant_i;
        if (irq_clear_i) begin
          dbg_res_flag_o <= 1'b0;
        end
      end
    end
  end

  // irq pin: pulse of chosen width or held low until cleared
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_n_o    <= 1'b1;
      irq_cnt_q  <= 20'd0;
      irq_hold_q <= 1'b0;
      half_q     <= 1'b0;
    end else begin
      half_q <= wd_half_i;
      if (irq_event_i || (misc_cfg_o[`SMR_MISC_IRQ_HALF] &&
          dev_mode_i == `SMR_MODE_REPROG && wd_half_i && !half_q)) begin
        irq_n_o <= 1'b0;
        irq_hold_q <= misc_cfg_o[`SMR_MISC_IRQ_LVL];
        irq_cnt_q <= misc_cfg_o[`SMR_MISC_IRQ_SHORT] ?
                     IRQ_SHORT : IRQ_LONG;
      end else if (irq_hold_q) begin
        if (irq_clear_i) begin
          irq_hold_q <= 1'b0;
          irq_n_o    <= 1'b1;
        end
      end else if (irq_cnt_q > 20'd1) begin
        irq_cnt_q <= irq_cnt_q - 20'd1;
      end else begin
        irq_cnt_q <= 20'd0;
        irq_n_o   <= 1'b1;
      end
    end
  end
endmodule // smr_regs
`default_nettype wire

// >>> hdl/smr_sync.v
// two flip-flop synchroniser for one level
`default_nettype none
module smr_sync (
  input  wire clk_sys_i,
  input  wire rst_i,
  input  wire d_i,
  output reg  q_o
);
  reg meta_q;

  // first stage is read only by the second
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      q_o    <= 1'b0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule // smr_sync
`default_nettype wire

// >>> pkg/smr_consts.vh
// constants for the setup misc and special mode register bank
`ifndef SMR_CONSTS_VH
`define SMR_CONSTS_VH
// register addresses (5-bit address field of the spi frame)
`define SMR_ADDR_MISC      5'h08
`define SMR_ADDR_SPEC      5'h09
// field positions of the misc setup register
`define SMR_MISC_LP_RND    7
`define SMR_MISC_PARITY    6
`define SMR_MISC_IRQ_LVL   5
`define SMR_MISC_IRQ_SHORT 4
`define SMR_MISC_IRQ_HALF  3
`define SMR_MISC_DBG_EN    2
// special mode field positions
`define SMR_SPEC_SEL_HI    7
`define SMR_SPEC_SEL_LO    6
// reset values
`define SMR_MISC_RST       8'h00
`define SMR_SPEC_RST       8'h00
// mode encodings (target select)
`define SMR_SEL_RESET      2'h0
`define SMR_SEL_SETUP      2'h1
`define SMR_SEL_REPROG     2'h2
// device modes reported by outside logic
`define SMR_MODE_NORMAL    3'h0
`define SMR_MODE_SETUP     3'h1
`define SMR_MODE_REPROG    3'h2
`define SMR_MODE_RESET     3'h3
// interrupt pulse widths
`define SMR_IRQ_LONG_NS    100000
`define SMR_IRQ_SHORT_NS   25000
`define SMR_CLK_NS         20
// pulse widths in clock cycles, sized to the 20-bit pulse counter
`define SMR_IRQ_LONG_CYC   20'h01388
`define SMR_IRQ_SHORT_CYC  20'h004e2
// spi frame width
`define SMR_FRAME_BITS     16
`endif

// >>> tb/smr_regs_chk.sv
// concurrent checks on the ports of the register bank
`default_nettype none
module smr_regs_chk (
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  input wire logic [2:0] dev_mode_i,
  input wire logic [7:0] misc_cfg_o,
  input wire logic       parity_err_o,
  input wire logic       irq_n_o,
  input wire logic [1:0] variant_o,
  input wire logic       mode_req_o,
  input wire logic [1:0] mode_sel_o,
  input wire logic       failsafe_n_o,
  input wire logic       wd_extend_ok_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic [12:0] low_q;
  // length of the current irq low phase, wraps only in level mode
  always_ff @(posedge clk_sys_i)
    low_q <= (rst_i || irq_n_o) ? 13'h0 : low_q + 13'h1;
  sequence s_one_shot;
    mode_req_o ##1 !mode_req_o;
  endsequence
  property p_lock;
    dev_mode_i != 3'h1 && $past(dev_mode_i) != 3'h1 |-> $stable(misc_cfg_o);
  endproperty
  a_lock: assert property (p_lock)
    else $error("misc moved outside setup");
  property p_par;
    parity_err_o |-> misc_cfg_o[6];
  endproperty
  a_par: assert property (p_par)
    else $error("parity error while unchecked");
  property p_width;
    !misc_cfg_o[5] |-> low_q <= (misc_cfg_o[4] ? 13'h4e4 : 13'h138a);
  endproperty
  a_width: assert property (p_width)
    else $error("irq pulse too long");
  property p_var;
    misc_cfg_o[2] && $stable(misc_cfg_o) |-> variant_o == misc_cfg_o[1:0];
  endproperty
  a_var: assert property (p_var)
    else $error("variant not from code");
  property p_req;
    mode_req_o |-> (mode_sel_o != 2'h3) ##0 s_one_shot;
  endproperty
  a_req: assert property (p_req)
    else $error("bad mode request");
  property p_setup;
    mode_req_o && mode_sel_o == 2'h1 |-> dev_mode_i == 3'h0;
  endproperty
  a_setup: assert property (p_setup)
    else $error("setup entry not from normal");
  property p_safe;
    $fell(failsafe_n_o) |-> dev_mode_i == 3'h1;
  endproperty
  a_safe: assert property (p_safe)
    else $error("failsafe outside setup");
  property p_wd;
    $stable(dev_mode_i) |-> wd_extend_ok_o == (dev_mode_i == 3'h2);
  endproperty
  a_wd: assert property (p_wd)
    else $error("watchdog extension wrong");
endmodule // smr_regs_chk
bind smr_regs smr_regs_chk i_chk (.*);
`default_nettype wire

// >>> tb/smr_spi_master.sv
// microcontroller side: spi master, mode 0, msb first
`default_nettype none
module smr_spi_master (
  input  wire logic clk_sys_i,
  input  wire logic miso_i,
  output var  logic sclk_o,
  output var  logic cs_n_o,
  output var  logic mosi_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus: clock low, chip deselected
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // pm: 0 parity zero, 1 odd parity, 2 deliberately wrong
  task automatic xfer(input logic [15:0] w, input logic [1:0] pm,
                      output logic [15:0] r);
    logic [15:0] f;
    f = w;
    f[8] = pm == 2'h1 ? ~^{w[15:9], w[7:0]} :
           pm == 2'h2 ? ^{w[15:9], w[7:0]} : 1'b0;
    @(posedge clk_sys_i) cs_n_o <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_o <= f[i];
      repeat (4) @(posedge clk_sys_i);
      sclk_o <= 1'b1;
      r[i] = miso_i;
      repeat (4) @(posedge clk_sys_i);
      sclk_o <= 1'b0;
    end
    repeat (4) @(posedge clk_sys_i);
    cs_n_o <= 1'b1;
    mosi_o <= ~mosi_o; // released line keeps no stale bit
    repeat (8) @(posedge clk_sys_i);
  endtask
endmodule // smr_spi_master
`default_nettype wire

// >>> tb/tb_setup_misc_and_special_mode_regs.sv
// self-checking bench for the setup misc and special mode bank
`default_nettype none
module tb_setup_misc_and_special_mode_regs;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [2:0] m; logic [7:0] d; logic [7:0] e;} smr_row_t;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, wd_half_i = 1'b0, pe;
  logic irq_event_i = 1'b0, irq_clear_i = 1'b0, spi_miso_o, irq_n_o;
  logic spi_sclk_i, spi_cs_n_i, spi_mosi_i, lp_need_code_o, parity_err_o;
  logic dbg_res_flag_o, mode_req_o, failsafe_n_o, wd_extend_ok_o;
  logic [2:0] dev_mode_i = 3'h0;
  logic [1:0] strap_variant_i = 2'h2, variant_o, mode_sel_o;
  logic [7:0] misc_cfg_o;
  logic [15:0] r;
  int errors, check_count, cyc, pe_cnt, req_cnt;
  // mode, data, expected register
  smr_row_t rows [8] = '{'{3'h1, 8'h84, 8'h84}, '{3'h0, 8'h3f, 8'h84},
    '{3'h2, 8'h3f, 8'h84}, '{3'h1, 8'hc7, 8'hc7}, '{3'h1, 8'h05, 8'h05},
    '{3'h1, 8'h30, 8'h30}, '{3'h3, 8'hff, 8'h30}, '{3'h1, 8'h70, 8'h70}};
  // mode, {target, code mask}, {request count, target}
  smr_row_t spec [6] = '{'{3'h0, 8'h7f, 8'h05}, '{3'h0, 8'h40, 8'h05},
    '{3'h0, 8'hff, 8'h05}, '{3'h1, 8'h7f, 8'h05}, '{3'h1, 8'hbf, 8'h0a},
    '{3'h1, 8'h3f, 8'h0c}};
  smr_regs i_dut (.*);
  smr_spi_master i_m (.clk_sys_i(clk_sys_i), .miso_i(spi_miso_o),
    .sclk_o(spi_sclk_i), .cs_n_o(spi_cs_n_i), .mosi_o(spi_mosi_i));
  always #10 clk_sys_i = ~clk_sys_i;
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // pulse counters and a hang guard well above the expected run
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    pe_cnt <= pe_cnt + parity_err_o;
    req_cnt <= req_cnt + mode_req_o;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    chk("misc", 8'h00, misc_cfg_o);
    chk("safe", 8'h01, {7'h0, failsafe_n_o});
    pe = 1'b0;
    foreach (rows[i]) begin
      @(posedge clk_sys_i) dev_mode_i <= rows[i].m;
      i_m.xfer({8'h50, rows[i].d}, {1'b0, pe}, r);
      chk("misc", rows[i].e, misc_cfg_o);
      chk("lp", {7'h0, rows[i].e[7]}, {7'h0, lp_need_code_o});
      chk("var", {6'h0, rows[i].e[2] ? rows[i].e[1:0] : 2'h2},
          {6'h0, variant_o});
      pe = rows[i].e[6];
    end
    chk("dbg", 8'h01, {7'h0, dbg_res_flag_o});
    i_m.xfer(16'h5000, 2'h2, r);
    chk("perr", 8'h01, pe_cnt[7:0]);
    chk("misc", 8'h70, misc_cfg_o);
    @(posedge clk_sys_i) irq_event_i <= 1'b1;
    @(posedge clk_sys_i) irq_event_i <= 1'b0;
    repeat (1300) @(posedge clk_sys_i);
    chk("irq", 8'h00, {7'h0, irq_n_o});
    @(posedge clk_sys_i) irq_clear_i <= 1'b1;
    @(posedge clk_sys_i) irq_clear_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    chk("irq", 8'h01, {7'h0, irq_n_o});
    i_m.xfer(16'h5058, 2'h1, r);
    chk("misc", 8'h58, misc_cfg_o);
    @(posedge clk_sys_i) irq_event_i <= 1'b1;
    @(posedge clk_sys_i) irq_event_i <= 1'b0;
    repeat (1200) @(posedge clk_sys_i);
    chk("pulse", 8'h00, {7'h0, irq_n_o});
    repeat (100) @(posedge clk_sys_i);
    chk("pulse", 8'h01, {7'h0, irq_n_o});
    foreach (spec[i]) begin
      @(posedge clk_sys_i) dev_mode_i <= spec[i].m;
      i_m.xfer(16'h1300, 2'h0, r);
      i_m.xfer({8'h52, spec[i].d[7:6], r[5:0] ^ spec[i].d[5:0]}, 2'h1, r);
      chk("req", {2'h0, spec[i].e[7:2]}, req_cnt[7:0]);
      chk("sel", {6'h0, spec[i].e[1:0]}, {6'h0, mode_sel_o});
    end
    i_m.xfer(16'h1300, 2'h0, r);
    i_m.xfer({8'h52, 2'h1, r[5:4], ~r[3:0]}, 2'h1, r);
    chk("safe", 8'h00, {7'h0, failsafe_n_o});
    @(posedge clk_sys_i) dev_mode_i <= 3'h2;
    repeat (4) @(posedge clk_sys_i);
    chk("wd", 8'h01, {7'h0, wd_extend_ok_o});
    @(posedge clk_sys_i) wd_half_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    chk("half", 8'h00, {7'h0, irq_n_o});
    stop_test();
  end
endmodule // tb_setup_misc_and_special_mode_regs
`default_nettype wire
